// ### logic/rtcg_regs.vh
// register map, field positions and reset values of the calendar clock register group
`ifndef RTCG_REGS_VH
`define RTCG_REGS_VH

// ============================================================
// offsets
`define RTCG_OFS_SHD_TIME   8'h00
`define RTCG_OFS_SHD_DATE   8'h04
`define RTCG_OFS_CTRL       8'h08
`define RTCG_OFS_STAT       8'h0C
`define RTCG_OFS_PSC        8'h10
`define RTCG_OFS_WUT        8'h14
`define RTCG_OFS_ALM0       8'h1C
`define RTCG_OFS_ALM1       8'h20
`define RTCG_OFS_WPK        8'h24
`define RTCG_OFS_SS         8'h28
`define RTCG_OFS_SHIFT      8'h2C
`define RTCG_OFS_TS_TIME    8'h30
`define RTCG_OFS_TS_DATE    8'h34

// ============================================================
// reset values
`define RTCG_RST_PSC        32'h007F00FF
`define RTCG_RST_WUT        16'hFFFF

// ============================================================
// control fields
`define RTCG_CTL_WCS_HI     2
`define RTCG_CTL_BYPASS     5
`define RTCG_CTL_ALM0_EN    8
`define RTCG_CTL_WUT_EN     10
`define RTCG_CTL_TS_EN      11
`define RTCG_CTL_MASK       32'h00000F27

// ============================================================
// status fields
`define RTCG_ST_ALM0_WOK    0
`define RTCG_ST_WUT_WOK     2
`define RTCG_ST_SHIFT_PEND  3
`define RTCG_ST_SYNC        5
`define RTCG_ST_INIT_F      6
`define RTCG_ST_INIT_REQ    7
`define RTCG_ST_ALM0_F      8
`define RTCG_ST_WUT_F       10
`define RTCG_ST_TS_F        11

// ============================================================
// prescaler, alarm, shift and stamp fields
`define RTCG_PSC_A_HI       22
`define RTCG_PSC_A_LO       16
`define RTCG_PSC_S_HI       14
`define RTCG_ALM_MSK_DAY    31
`define RTCG_ALM_WDAY_SEL   30
`define RTCG_ALM_MSK_HOUR   23
`define RTCG_ALM_PM         22
`define RTCG_ALM_MSK_MIN    15
`define RTCG_ALM_MSK_SEC    7
`define RTCG_SH_ADD_SEC     31
`define RTCG_TIME_MASK      32'h007F7F7F
`define RTCG_DATE_MASK      32'h0000FF3F

`endif

// ### logic/rtcg_core.v
// calendar clock register group: prescaler, wakeup timer, alarms, shift, stamp
//
// Notes on behaviour
// - status bit 2 reads 1 when the wakeup reload may be written
// - each alarm write-ok flag sets once its alarm enable is cleared
// - first stage tick = rtc input ticks divided by async factor plus one
// - seconds tick = first stage ticks divided by sync factor plus one
// - wakeup flag sets every reload plus one periods of the wakeup clock
// - wakeup reload accepts writes only while its write-ok flag is 1
// - alarm mask bits drop day, hour, minute, second from the comparison
// - weekday select makes day units a weekday and ignores day tens
// - alarms hold bcd tens and units of day, hour, minute, second
// - bit 22 is the afternoon flag in alarms and the stamp time
// - prescaler and alarms accept writes only in initialization state
// - an 8-bit key field governs write protection of protected registers
// - sub-second readout returns the synchronous down-counter
// - fraction of second is (sync factor minus count) over (sync factor plus one)
// - system reset clears sub-second count unless shadow bypass is set
// - shift control accepts writes only while no shift is pending
// - written fraction is added to the synchronous down-counter
// - add-one-second with a fraction advances the clock by one minus fraction
// - any write to shift control clears the shadow sync flag
// - stamp flag set captures calendar time and date into stamp registers
// - clearing the stamp flag clears both stamp registers
// - wakeup clock is rtc/16, /8, /4, /2, or seconds, optionally plus 2^16
// - init request enters a flagged initialization state where counting stops
// - shift pending reads 1 until a requested shift is carried out
// - with shadow bypass the calendar reads return live counters
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "rtcg_regs.vh"

module rtcg_core #(
    parameter [7:0] KEY_FIRST  = 8'hA5,  // arbitrary unlock pair
    parameter [7:0] KEY_SECOND = 8'h5A
) (
    // clock and resets
    input  wire        clk,
    input  wire        rst,
    input  wire        sys_rst,
    // register port
    input  wire [7:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [31:0] bus_rdata,
    // clock source and events
    input  wire        rtc_input_clock,
    input  wire        timestamp_event,
    // live calendar from the counters outside
    input  wire [31:0] cal_time,
    input  wire [31:0] cal_date,
    // ticks and flags toward the calendar
    output reg         first_stage_clock,
    output reg         seconds_clock,
    output reg         add_second_pulse,
    output wire        init_state_flag,
    output wire        wakeup_flag,
    output wire        alarm_flags_any
);

// ============================================================
// registers
reg  [31:0] ctrl_r;
reg  [31:0] psc_r;
reg  [15:0] wakeup_reload_value_r;
reg  [31:0] alarm_r [0:1];
reg         unlock_r;
reg         key_half_r;
reg         init_request_r;
reg         init_state_r;
reg  [1:0]  alarm_write_ok_r;
reg         wakeup_write_ok_r;
reg  [1:0]  alarm_flag_r;
reg  [1:0]  alarm_hit_d_r;
reg         wakeup_flag_r;
reg         timestamp_flag_r;
reg         shift_pending_r;
reg         add_one_second_r;
reg  [14:0] fraction_shift_r;
reg         shadow_sync_flag_r;
reg         sync_phase_r;
reg  [31:0] shd_time_r;
reg  [31:0] shd_date_r;
reg  [31:0] ts_time_r;
reg  [31:0] ts_date_r;
reg  [6:0]  async_cnt_r;
reg  [15:0] subsecond_value_r;
reg  [3:0]  rtc_div_r;
reg  [16:0] wakeup_cnt_r;

wire [2:0]  wakeup_clock_select = ctrl_r[`RTCG_CTL_WCS_HI:0];
wire        shadow_bypass       = ctrl_r[`RTCG_CTL_BYPASS];
wire [1:0]  alarm_enable        = ctrl_r[`RTCG_CTL_ALM0_EN+1:`RTCG_CTL_ALM0_EN];
wire        wakeup_enable       = ctrl_r[`RTCG_CTL_WUT_EN];
wire        timestamp_enable    = ctrl_r[`RTCG_CTL_TS_EN];
wire [6:0]  factor_a            = psc_r[`RTCG_PSC_A_HI:`RTCG_PSC_A_LO];
wire [14:0] factor_s            = psc_r[`RTCG_PSC_S_HI:0];

// ============================================================
// decode
function sel;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        sel = (addr == ofs);
    end
endfunction

// alarm comparison against the live calendar
function alarm_hit;
    input [31:0] alm;
    input [31:0] tm;
    input [31:0] dt;
    reg          day_ok;
    begin
        if (alm[`RTCG_ALM_WDAY_SEL]) begin
            day_ok = (alm[27:24] == {1'b0, dt[15:13]});
        end else begin
            day_ok = (alm[29:24] == dt[5:0]);
        end
        alarm_hit = (alm[`RTCG_ALM_MSK_DAY] | day_ok) &
                    (alm[`RTCG_ALM_MSK_HOUR] | (alm[22:16] == tm[22:16])) &
                    (alm[`RTCG_ALM_MSK_MIN] | (alm[14:8] == tm[14:8])) &
                    (alm[`RTCG_ALM_MSK_SEC] | (alm[6:0] == tm[6:0]));
    end
endfunction

wire wr_ctrl   = bus_wr & sel(bus_addr, `RTCG_OFS_CTRL) & unlock_r;
wire wr_stat   = bus_wr & sel(bus_addr, `RTCG_OFS_STAT);
wire wr_psc    = bus_wr & sel(bus_addr, `RTCG_OFS_PSC) & unlock_r & init_state_r;
wire wr_wut    = bus_wr & sel(bus_addr, `RTCG_OFS_WUT) & unlock_r & wakeup_write_ok_r;
wire wr_alm0   = bus_wr & sel(bus_addr, `RTCG_OFS_ALM0) & unlock_r & init_state_r;
wire wr_alm1   = bus_wr & sel(bus_addr, `RTCG_OFS_ALM1) & unlock_r & init_state_r;
wire wr_key    = bus_wr & sel(bus_addr, `RTCG_OFS_WPK);
wire shift_hit = bus_wr & sel(bus_addr, `RTCG_OFS_SHIFT);
wire wr_shift  = shift_hit & unlock_r & ~shift_pending_r;

// ============================================================
// prescaler chain
// the rtc source is a one-cycle tick, so both stages stay in the clk domain
wire apre_tick = rtc_input_clock & ~init_state_r & (async_cnt_r == 7'h00);
wire spre_tick = apre_tick & (subsecond_value_r == 16'h0000);

always @(posedge clk) begin
    if (rst) begin
        async_cnt_r       <= 7'h7F;
        subsecond_value_r <= 16'h0000;
        first_stage_clock <= 1'b0;
        seconds_clock     <= 1'b0;
        add_second_pulse  <= 1'b0;
    end else begin
        first_stage_clock <= apre_tick;
        seconds_clock     <= spre_tick;
        add_second_pulse  <= 1'b0;
        if (init_state_r) begin
            async_cnt_r <= factor_a;
        end else if (rtc_input_clock) begin
            if (async_cnt_r == 7'h00) begin
                async_cnt_r <= factor_a;
            end else begin
                async_cnt_r <= async_cnt_r - 7'h01;
            end
        end
        if (sys_rst & ~shadow_bypass) begin
            subsecond_value_r <= 16'h0000;
        end else if (init_state_r) begin
            subsecond_value_r <= {1'b0, factor_s};
        end else if (apre_tick & shift_pending_r) begin
            // the shift lands on a prescaler step so no edge is lost
            subsecond_value_r <= subsecond_value_r + {1'b0, fraction_shift_r};
            add_second_pulse  <= add_one_second_r;
        end else if (apre_tick) begin
            if (subsecond_value_r == 16'h0000) begin
                subsecond_value_r <= {1'b0, factor_s};
            end else begin
                subsecond_value_r <= subsecond_value_r - 16'h0001;
            end
        end
    end
end

// ============================================================
// wakeup timer
function wut_tick;
    input [2:0] wcs;
    input [3:0] div;
    input       rtc;
    input       spre;
    begin
        case (wcs)
            3'h0: wut_tick = rtc & (div == 4'hF);
            3'h1: wut_tick = rtc & (div[2:0] == 3'h7);
            3'h2: wut_tick = rtc & (div[1:0] == 2'h3);
            3'h3: wut_tick = rtc & div[0];
            default: wut_tick = spre;
        endcase
    end
endfunction

wire        wakeup_clock = wut_tick(wakeup_clock_select, rtc_div_r, rtc_input_clock, spre_tick);
wire [16:0] wut_load     = {wakeup_clock_select[2] & wakeup_clock_select[1], wakeup_reload_value_r};
wire        wut_fire     = wakeup_enable & wakeup_clock & (wakeup_cnt_r == 17'h00000);

always @(posedge clk) begin
    if (rst) begin
        rtc_div_r         <= 4'h0;
        wakeup_cnt_r      <= 17'h0FFFF;
        wakeup_write_ok_r <= 1'b1;
        alarm_write_ok_r  <= 2'b11;
    end else begin
        if (rtc_input_clock) begin
            rtc_div_r <= rtc_div_r + 4'h1;
        end
        wakeup_write_ok_r <= ~wakeup_enable;
        alarm_write_ok_r  <= ~alarm_enable;
        if (~wakeup_enable) begin
            wakeup_cnt_r <= wut_load;
        end else if (wakeup_clock) begin
            if (wakeup_cnt_r == 17'h00000) begin
                wakeup_cnt_r <= wut_load;
            end else begin
                wakeup_cnt_r <= wakeup_cnt_r - 17'h00001;
            end
        end
    end
end

// ============================================================
// alarms
wire [1:0] alarm_hit_now;
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_alarm
        assign alarm_hit_now[gi] = alarm_enable[gi] & alarm_hit(alarm_r[gi], cal_time, cal_date);
    end
endgenerate
wire [1:0] alarm_set = alarm_hit_now & ~alarm_hit_d_r;

// ============================================================
// status, key, control and configuration writes
wire ts_set   = timestamp_event & timestamp_enable;
wire ts_clear = wr_stat & ~bus_wdata[`RTCG_ST_TS_F] & ~ts_set;

always @(posedge clk) begin
    if (rst) begin
        ctrl_r                <= 32'h00000000;
        psc_r                 <= `RTCG_RST_PSC;
        wakeup_reload_value_r <= `RTCG_RST_WUT;
        alarm_r[0]            <= 32'h00000000;
        alarm_r[1]            <= 32'h00000000;
        unlock_r              <= 1'b0;
        key_half_r            <= 1'b0;
        init_request_r        <= 1'b0;
        init_state_r          <= 1'b0;
        alarm_flag_r          <= 2'b00;
        alarm_hit_d_r         <= 2'b00;
        wakeup_flag_r         <= 1'b0;
        timestamp_flag_r      <= 1'b0;
        shift_pending_r       <= 1'b0;
        add_one_second_r      <= 1'b0;
        fraction_shift_r      <= 15'h0000;
        ts_time_r             <= 32'h00000000;
        ts_date_r             <= 32'h00000000;
    end else begin
        // key: the pair unlocks, anything else locks again
        if (wr_key) begin
            key_half_r <= (bus_wdata[7:0] == KEY_FIRST);
            unlock_r   <= key_half_r & (bus_wdata[7:0] == KEY_SECOND);
        end
        if (wr_ctrl) begin
            ctrl_r <= bus_wdata & `RTCG_CTL_MASK;
        end
        if (wr_psc) begin
            psc_r <= {9'h000, bus_wdata[`RTCG_PSC_A_HI:`RTCG_PSC_A_LO], 1'b0, bus_wdata[`RTCG_PSC_S_HI:0]};
        end
        if (wr_wut) begin
            wakeup_reload_value_r <= bus_wdata[15:0];
        end
        if (wr_alm0) begin
            alarm_r[0] <= bus_wdata;
        end
        if (wr_alm1) begin
            alarm_r[1] <= bus_wdata;
        end
        if (wr_stat & unlock_r) begin
            init_request_r <= bus_wdata[`RTCG_ST_INIT_REQ];
        end
        init_state_r  <= init_request_r;
        alarm_hit_d_r <= alarm_hit_now;
        // hardware set wins over a software clear in the same cycle
        alarm_flag_r  <= alarm_set |
                         (alarm_flag_r & ~({2{wr_stat}} & ~bus_wdata[`RTCG_ST_ALM0_F+1:`RTCG_ST_ALM0_F]));
        wakeup_flag_r <= wut_fire | (wakeup_flag_r & ~(wr_stat & ~bus_wdata[`RTCG_ST_WUT_F]));
        if (ts_set) begin
            timestamp_flag_r <= 1'b1;
            if (~timestamp_flag_r) begin
                ts_time_r <= cal_time & `RTCG_TIME_MASK;
                ts_date_r <= cal_date & `RTCG_DATE_MASK;
            end
        end else if (ts_clear) begin
            timestamp_flag_r <= 1'b0;
            ts_time_r        <= 32'h00000000;
            ts_date_r        <= 32'h00000000;
        end
        if (wr_shift) begin
            shift_pending_r  <= 1'b1;
            add_one_second_r <= bus_wdata[`RTCG_SH_ADD_SEC];
            fraction_shift_r <= bus_wdata[14:0];
        end else if (apre_tick) begin
            shift_pending_r  <= 1'b0;
        end
    end
end

// ============================================================
// shadow copies of the calendar
always @(posedge clk) begin
    if (rst) begin
        shadow_sync_flag_r <= 1'b0;
        sync_phase_r       <= 1'b0;
        shd_time_r         <= 32'h00000000;
        shd_date_r         <= 32'h00000000;
    end else begin
        if (rtc_input_clock) begin
            sync_phase_r <= ~sync_phase_r;
        end
        if (shift_hit | init_request_r | shift_pending_r | shadow_bypass) begin
            shadow_sync_flag_r <= 1'b0;
        end else if (rtc_input_clock & sync_phase_r) begin
            shadow_sync_flag_r <= 1'b1;
            shd_time_r         <= cal_time & `RTCG_TIME_MASK;
            shd_date_r         <= cal_date & `RTCG_DATE_MASK;
        end else if (wr_stat & ~bus_wdata[`RTCG_ST_SYNC]) begin
            shadow_sync_flag_r <= 1'b0;
        end
    end
end

// ============================================================
// read port
wire [31:0] status_word = {20'h00000, timestamp_flag_r, wakeup_flag_r, alarm_flag_r,
                           init_request_r, init_state_r, shadow_sync_flag_r, 1'b0,
                           shift_pending_r, wakeup_write_ok_r, alarm_write_ok_r[1],
                           alarm_write_ok_r[0]};
reg  [31:0] rd_nxt;

always @* begin
    case (bus_addr)
        `RTCG_OFS_SHD_TIME: rd_nxt = shadow_bypass ? (cal_time & `RTCG_TIME_MASK) : shd_time_r;
        `RTCG_OFS_SHD_DATE: rd_nxt = shadow_bypass ? (cal_date & `RTCG_DATE_MASK) : shd_date_r;
        `RTCG_OFS_CTRL:     rd_nxt = ctrl_r;
        `RTCG_OFS_STAT:     rd_nxt = status_word;
        `RTCG_OFS_PSC:      rd_nxt = psc_r;
        `RTCG_OFS_WUT:      rd_nxt = {16'h0000, wakeup_reload_value_r};
        `RTCG_OFS_ALM0:     rd_nxt = alarm_r[0];
        `RTCG_OFS_ALM1:     rd_nxt = alarm_r[1];
        // software derives the second fraction from these two values
        `RTCG_OFS_SS:       rd_nxt = {16'h0000, subsecond_value_r};
        `RTCG_OFS_TS_TIME:  rd_nxt = ts_time_r;
        `RTCG_OFS_TS_DATE:  rd_nxt = ts_date_r;
        default:            rd_nxt = 32'h00000000;
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        bus_rdata <= 32'h00000000;
    end else begin
        bus_rdata <= bus_rd ? rd_nxt : 32'h00000000;
    end
end

assign init_state_flag = init_state_r;
assign wakeup_flag     = wakeup_flag_r;
assign alarm_flags_any = |alarm_flag_r;

endmodule

// ### verif/rtcg_core_properties.sv
// port-level assertions for the calendar clock register group
`timescale 1ns/1ps
`include "rtcg_regs.vh"
module rtcg_core_properties (
    // clock and resets
    input wire        clk,
    input wire        rst,
    input wire        sys_rst,
    // register port
    input wire [7:0]  bus_addr,
    input wire [31:0] bus_wdata,
    input wire        bus_wr,
    input wire        bus_rd,
    input wire [31:0] bus_rdata,
    // clock source and events
    input wire        rtc_input_clock,
    input wire        timestamp_event,
    input wire [31:0] cal_time,
    input wire [31:0] cal_date,
    // ticks and flags
    input wire        first_stage_clock,
    input wire        seconds_clock,
    input wire        add_second_pulse,
    input wire        init_state_flag,
    input wire        wakeup_flag,
    input wire        alarm_flags_any
);
    // ============================================================
    // helpers
    wire stat_wr = bus_wr && bus_addr == `RTCG_OFS_STAT;
    wire init_wr = stat_wr && bus_wdata[`RTCG_ST_INIT_REQ];
    wire rd_ss   = bus_rd && bus_addr == `RTCG_OFS_SS;
    wire rd_ts   = bus_rd && bus_addr == `RTCG_OFS_TS_TIME;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ============================================================
    // assertions
    chk_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data seen outside a read slot");
    chk_first_tick: assert property (first_stage_clock |-> $past(rtc_input_clock))
        else $error("first stage pulse without an input tick");
    chk_sec_tick: assert property (seconds_clock |-> $past(rtc_input_clock))
        else $error("seconds pulse without an input tick");
    chk_shift_tick: assert property (add_second_pulse |-> $past(rtc_input_clock))
        else $error("add second pulse off a prescaler step");
    chk_init_cause: assert property ($rose(init_state_flag) |-> $past(init_wr, 2))
        else $error("init state entered without a request two cycles before");
    chk_wake_hold: assert property ($fell(wakeup_flag) |-> $past(stat_wr) && !$past(bus_wdata[10]))
        else $error("wakeup flag dropped without a clearing write");
    chk_alarm_hold: assert property ($fell(alarm_flags_any) |-> $past(stat_wr))
        else $error("alarm flag dropped without a clearing write");
    chk_ss_width: assert property ($past(rd_ss) |-> bus_rdata[31:16] == 16'h0)
        else $error("sub-second readout upper half not zero");
    chk_stamp_bits: assert property ($past(rd_ts) |-> (bus_rdata & ~`RTCG_TIME_MASK) == 32'h0)
        else $error("stamp time reserved bits set");

    // ============================================================
    // covers
    cov_wake:  cover property ($rose(wakeup_flag));
    cov_alarm: cover property ($rose(alarm_flags_any));
    cov_shift: cover property (add_second_pulse);
    cov_sec:   cover property (seconds_clock);
endmodule

// ### verif/tb_rtcg_core.sv
// self-checking testbench for the calendar clock register group
`timescale 1ns/1ps
`include "rtcg_regs.vh"
module tb_rtcg_core;
    // ============================================================
    // signals
    reg         clk, rst, sys_rst, bus_wr, bus_rd, rtc_input_clock, timestamp_event, tick_en;
    reg  [7:0]  bus_addr;
    reg  [31:0] bus_wdata, cal_time, cal_date, rd_v, v1;
    wire [31:0] bus_rdata;
    wire        first_stage_clock, seconds_clock, add_second_pulse;
    wire        init_state_flag, wakeup_flag, alarm_flags_any;
    wire [4:0]  sigs = {add_second_pulse, alarm_flags_any, wakeup_flag, seconds_clock, first_stage_clock};
    int         num_errors, checks_done, n;
    time        t0;
    // reset image: address beside expected read data
    logic [39:0] rows [10] = '{{8'h10, 32'h007F00FF}, {8'h14, 32'h0000FFFF}, {8'h1C, 32'h0},
        {8'h20, 32'h0}, {8'h28, 32'h0}, {8'h30, 32'h0}, {8'h34, 32'h0}, {8'h0C, 32'h7},
        {8'h08, 32'h0}, {8'h18, 32'h0}};

    rtcg_core rtcg_core_i (.*);

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // input ticks every second clock, stopped while tick_en is low
    always @(posedge clk) rtc_input_clock <= tick_en && !rtc_input_clock;

    // ============================================================
    // tasks
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        bus_wr <= 1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk);
        bus_rd <= 1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 0;
        #1 rd_v = bus_rdata;
    endtask
    // bounded wait for a pulse or flag, one sample per cycle
    task wait_hi(input int s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sigs[s] !== 1'b1 && n < lim);
        chk(sigs[s], 1, "signal did not arrive");
    endtask
    task gap(input int s, input int exp);
        wait_hi(s, 300);
        t0 = $time;
        if (s == 2) wr(`RTCG_OFS_STAT, 0);
        wait_hi(s, 300);
        chk(32'(($time - t0) / 8), exp, "period");
    endtask

    // ============================================================
    // tests
    initial begin
        {sys_rst, bus_wr, bus_rd, timestamp_event, tick_en} = 0;
        {bus_addr, bus_wdata, cal_time, cal_date} = 0;
        rst = 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        foreach (rows[i]) begin
            rd(rows[i][39:32]);
            chk(rd_v, rows[i][31:0], "reset value");
        end
        $display("test reset values done");
        wr(`RTCG_OFS_CTRL, 32'h20);
        rd(`RTCG_OFS_CTRL);
        chk(rd_v, 0, "locked control write");
        wr(`RTCG_OFS_WPK, 32'hA5);
        wr(`RTCG_OFS_WPK, 32'h5A);
        wr(`RTCG_OFS_PSC, 32'h00010003);
        rd(`RTCG_OFS_PSC);
        chk(rd_v, `RTCG_RST_PSC, "prescaler outside init");
        wr(`RTCG_OFS_STAT, 32'h80);
        rd(`RTCG_OFS_STAT);
        chk({rd_v[7:6], init_state_flag}, 3'b111, "init state");
        wr(`RTCG_OFS_PSC, 32'h00010003);
        wr(`RTCG_OFS_ALM0, 32'h80C08025);
        wr(`RTCG_OFS_ALM1, 32'h73808080);
        rd(`RTCG_OFS_PSC);
        chk(rd_v, 32'h00010003, "prescaler in init");
        rd(`RTCG_OFS_ALM0);
        chk(rd_v, 32'h80C08025, "alarm zero image");
        wr(`RTCG_OFS_STAT, 0);
        $display("test protection done");
        tick_en <= 1;
        gap(0, 4);
        gap(1, 16);
        rd(`RTCG_OFS_SS);
        chk(rd_v <= 3, 1, "sub-second range");
        rd(`RTCG_OFS_STAT);
        chk(rd_v[5], 1, "sync flag running");
        tick_en <= 0;
        wr(`RTCG_OFS_SHIFT, 32'h80000001);
        // refused while pending, else the add-second pulse below never comes
        wr(`RTCG_OFS_SHIFT, 32'h00000000);
        rd(`RTCG_OFS_STAT);
        chk(rd_v[5:3], 3'b001, "shift pending, sync cleared");
        tick_en <= 1;
        wait_hi(4, 40);
        rd(`RTCG_OFS_STAT);
        chk(rd_v[3], 0, "shift done");
        $display("test prescaler and shift done");
        // reload 1 keeps clear of the forbidden zero with divide by two
        for (int w = 0; w < 5; w++) begin
            wr(`RTCG_OFS_CTRL, w);
            wr(`RTCG_OFS_WUT, 1);
            wr(`RTCG_OFS_CTRL, 32'h400 | w);
            rd(`RTCG_OFS_STAT);
            chk(rd_v[2], 0, "wakeup write-ok while enabled");
            gap(2, w < 4 ? 64 >> w : 32);
            wr(`RTCG_OFS_STAT, 0);
        end
        wr(`RTCG_OFS_WUT, 5);
        rd(`RTCG_OFS_WUT);
        chk(rd_v, 1, "wakeup reload refused");
        $display("test wakeup done");
        cal_time <= 32'h24;
        wr(`RTCG_OFS_CTRL, 32'h100);
        rd(`RTCG_OFS_STAT);
        chk(rd_v[0], 0, "alarm write-ok while enabled");
        repeat (10) @(posedge clk);
        #1 chk(alarm_flags_any, 0, "second field compared");
        cal_time <= 32'h00123425;
        wait_hi(3, 10);
        wr(`RTCG_OFS_CTRL, 0);
        wr(`RTCG_OFS_STAT, 0);
        rd(`RTCG_OFS_STAT);
        chk(rd_v[1:0], 2'b11, "alarm write-ok after disable");
        cal_date <= 32'h8000;
        wr(`RTCG_OFS_CTRL, 32'h200);
        repeat (10) @(posedge clk);
        #1 chk(alarm_flags_any, 0, "weekday mismatch");
        cal_date <= 32'h6000;
        wait_hi(3, 10);
        $display("test alarms done");
        wr(`RTCG_OFS_CTRL, 32'h800);
        wr(`RTCG_OFS_STAT, 0);
        cal_time <= 32'h80D23425;
        cal_date <= 32'hFFFF;
        @(posedge clk);
        timestamp_event <= 1;
        @(posedge clk);
        timestamp_event <= 0;
        rd(`RTCG_OFS_TS_TIME);
        chk(rd_v, 32'h00523425, "stamp time");
        rd(`RTCG_OFS_TS_DATE);
        chk(rd_v, 32'h0000FF3F, "stamp date");
        wr(`RTCG_OFS_STAT, 0);
        rd(`RTCG_OFS_TS_TIME);
        chk(rd_v, 0, "stamp cleared");
        $display("test stamp done");
        tick_en <= 0;
        @(posedge clk);
        sys_rst <= 1;
        @(posedge clk);
        sys_rst <= 0;
        rd(`RTCG_OFS_SS);
        chk(rd_v, 0, "system reset clears sub-second");
        wr(`RTCG_OFS_CTRL, 32'h20);
        tick_en <= 1;
        repeat (6) @(posedge clk);
        tick_en <= 0;
        rd(`RTCG_OFS_SS);
        v1 = rd_v;
        sys_rst <= 1;
        @(posedge clk);
        sys_rst <= 0;
        rd(`RTCG_OFS_SS);
        chk(rd_v, v1, "bypass keeps sub-second");
        // shadow copy is frozen under bypass, so only a live read shows this
        cal_time <= 32'h00112233;
        rd(`RTCG_OFS_SHD_TIME);
        chk(rd_v, 32'h00112233, "bypass reads live time");
        $display("test system reset done");
        report_and_stop;
    end

    // a hang is cut short well beyond the expected run
    initial begin
        #200000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop;
    end
endmodule

bind rtcg_core rtcg_core_properties rtcg_core_properties_i (.*);
